/* design/pswd_cost.sv */
// Extra-cycle cost of one data access through the window.
// Purely combinational; the caller registers the result.
`timescale 1ns/10ps
module pswd_cost
   import pswd_pkg::*;
(
   input  wire pswd_req_type req,
   input  wire logic         windowed,
   output logic [1:0]        extra
);

   // ----------------------------------------------------------------
   // Cost table
   // ----------------------------------------------------------------
   always_comb begin
      extra = EXTRA_NONE;
      if (windowed) begin
         if (req.inRepeat) begin
            // Only the loop boundaries pay; steady iterations run at full speed
            if (req.firstIter || req.lastIter || req.intExit || req.reEntry) begin
               extra = EXTRA_TWO;
            end else begin
               extra = EXTRA_NONE;
            end
         end else if (req.kind == KIND_WORD || req.kind == KIND_DWORD) begin
            extra = EXTRA_ONE;
         end else begin
            extra = EXTRA_TWO;
         end
      end
   end

endmodule // pswd_cost

/* design/pswd_pkg.sv */
// Constants and carrier types for the program-space data window.
// Assumes a single core clock domain and a synchronous active-high reset.
//
// What this block does
// - Top 32K data maps onto any 32K-word page
// - Redirect only when address MSB and enable set
// - Page register is 8 bits, 256 pages
// - Program address is page over low 15 bits
// - Low 15 data bits map one-to-one
// - Windowed read adds one cycle
// - Return low 16 bits, drop upper byte
// - Window suspended during table read or write
// - Outside repeat: moves +1, others +2 cycles
// - Repeat first, last, interrupt exit, re-entry: +2
// - Other repeat iterations: no extra cycles
package pswd_pkg;

   // ----------------------------------------------------------------
   // Register map and fields
   // ----------------------------------------------------------------
   localparam logic [11:0] PAGE_OFS     = 12'h000;
   localparam logic [11:0] CTRL_OFS     = 12'h004;
   localparam logic [11:0] STAT_OFS     = 12'h008;
   localparam int          WIN_EN_BIT   = 2;
   localparam int          BUSY_BIT     = 0;
   localparam int          CNT_LSB      = 16;
   localparam logic [7:0]  PAGE_RST     = 8'h00;
   localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
   localparam logic [31:0] RDATA_ZERO   = 32'h0000_0000;

   // ----------------------------------------------------------------
   // Address and data geometry
   // ----------------------------------------------------------------
   localparam int          PAGE_W       = 8;
   localparam int          LOW_W        = 15;
   localparam int          ADDR_MSB     = 15;
   localparam int          PM_ADDR_W    = PAGE_W + LOW_W;
   localparam int          PM_WORD_W    = 24;
   localparam int          DATA_W       = 16;

   // ----------------------------------------------------------------
   // Extra-cycle costs
   // ----------------------------------------------------------------
   localparam logic [1:0]  EXTRA_NONE   = 2'h0;
   localparam logic [1:0]  EXTRA_ONE    = 2'h1;
   localparam logic [1:0]  EXTRA_TWO    = 2'h2;

   typedef enum logic [1:0] {
      KIND_WORD  = 2'h0,
      KIND_DWORD = 2'h1,
      KIND_OTHER = 2'h2
   } pswd_kind_type;

   typedef enum logic [5:0] {
      ST_IDLE   = 6'h01,
      ST_DREAD  = 6'h02,
      ST_DCAP   = 6'h04,
      ST_PFET1  = 6'h08,
      ST_PFET2  = 6'h10,
      ST_PCAP   = 6'h20
   } pswd_state_type;

   typedef struct packed {
      logic [DATA_W-1:0] addr;
      pswd_kind_type     kind;
      logic              inRepeat;
      logic              firstIter;
      logic              lastIter;
      logic              intExit;
      logic              reEntry;
   } pswd_req_type;

   typedef struct packed {
      logic [DATA_W-1:0] data;
      logic              fromProgram;
      logic [1:0]        extra;
   } pswd_rsp_type;

endpackage

/* design/pswd_window.sv */
// Program-space data window: AHB-Lite register slave plus access router.
// Assumes program and data memory answer one cycle after their request.
//
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module pswd_window
   import pswd_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 rst,
   input  wire logic                 hsel,
   input  wire logic [31:0]          haddr,
   input  wire logic [1:0]           htrans,
   input  wire logic                 hwrite,
   input  wire logic [2:0]           hsize,
   input  wire logic [31:0]          hwdata,
   input  wire logic                 hready,
   output logic                      hreadyout,
   output logic                      hresp,
   output logic [31:0]               hrdata,
   input  wire logic                 cpuValid,
   input  wire pswd_req_type         cpuReq,
   input  wire logic                 tableActive,
   output logic                      cpuReady,
   output logic                      rspValid,
   output pswd_rsp_type              rsp,
   output logic                      pmReq,
   output logic [PM_ADDR_W-1:0]      pmAddr,
   input  wire logic [PM_WORD_W-1:0] pmRdData,
   output logic                      dmReq,
   output logic [DATA_W-1:0]         dmAddr,
   input  wire logic [DATA_W-1:0]    dmRdData
);

   // ----------------------------------------------------------------
   // Register state
   // ----------------------------------------------------------------
   logic [PAGE_W-1:0]  page;
   logic [PAGE_W-1:0]  next_page;
   logic               winEnable;
   logic               next_winEnable;
   logic [15:0]        winCount;
   logic [15:0]        next_winCount;
   logic               wrPending;
   logic               next_wrPending;
   logic [11:0]        wrOfs;
   logic [11:0]        next_wrOfs;
   logic [31:0]        next_hrdata;

   // ----------------------------------------------------------------
   // Access state
   // ----------------------------------------------------------------
   pswd_state_type     state;
   pswd_state_type     next_state;
   pswd_rsp_type       next_rsp;
   logic               next_rspValid;
   logic               next_cpuReady;
   logic               next_pmReq;
   logic [PM_ADDR_W-1:0] next_pmAddr;
   logic               next_dmReq;
   logic [DATA_W-1:0]  next_dmAddr;
   logic [1:0]         heldExtra;
   logic [1:0]         next_heldExtra;
   logic [1:0]         costExtra;
   logic               accept;
   logic               windowed;
   logic               addrPhase;

   function automatic logic hits_window(input logic en, input logic [DATA_W-1:0] a,
                                        input logic tbl);
      hits_window = en && a[ADDR_MSB] && !tbl;
   endfunction

   assign accept    = cpuValid && cpuReady;
   // Table instructions own the program bus, so the window yields to them
   assign windowed  = hits_window(winEnable, cpuReq.addr, tableActive);
   assign addrPhase = hsel && hready && htrans[1];

   pswd_cost u_cost (
      .req      (cpuReq),
      .windowed (windowed),
      .extra    (costExtra)
   );

   // ----------------------------------------------------------------
   // Bus slave: zero wait states, always OKAY
   // ----------------------------------------------------------------
   always_comb begin
      next_page      = page;
      next_winEnable = winEnable;
      next_winCount  = winCount;
      next_wrPending = 1'b0;
      next_wrOfs     = wrOfs;
      next_hrdata    = RDATA_ZERO;
      if (wrPending) begin
         if (wrOfs == PAGE_OFS) begin
            next_page = hwdata[PAGE_W-1:0];
         end
         if (wrOfs == CTRL_OFS) begin
            next_winEnable = hwdata[WIN_EN_BIT];
         end
      end
      if (addrPhase && hwrite) begin
         next_wrPending = 1'b1;
         next_wrOfs     = haddr[11:0];
      end else if (addrPhase) begin
         // Unmapped offsets read as zero
         case (haddr[11:0])
            PAGE_OFS: next_hrdata[PAGE_W-1:0]  = page;
            CTRL_OFS: next_hrdata[WIN_EN_BIT] = winEnable;
            STAT_OFS: begin
               next_hrdata[BUSY_BIT]          = (state != ST_IDLE);
               next_hrdata[CNT_LSB +: 16]     = winCount;
            end
            default:  next_hrdata = RDATA_ZERO;
         endcase
      end
      if (accept && windowed) begin
         next_winCount = winCount + 16'h0001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         page      <= PAGE_RST;
         winEnable <= CTRL_RST[WIN_EN_BIT];
         winCount  <= 16'h0000;
         wrPending <= 1'b0;
         wrOfs     <= 12'h000;
         hrdata    <= RDATA_ZERO;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end else begin
         page      <= next_page;
         winEnable <= next_winEnable;
         winCount  <= next_winCount;
         wrPending <= next_wrPending;
         wrOfs     <= next_wrOfs;
         hrdata    <= next_hrdata;
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Access router
   // ----------------------------------------------------------------
   always_comb begin
      next_state     = state;
      next_rsp       = rsp;
      next_rspValid  = 1'b0;
      next_pmReq     = 1'b0;
      next_pmAddr    = pmAddr;
      next_dmReq     = 1'b0;
      next_dmAddr    = dmAddr;
      next_heldExtra = heldExtra;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_heldExtra = costExtra;
               if (windowed) begin
                  // Page supplies the top bits; any page of 256 reachable
                  next_pmAddr = {page, cpuReq.addr[LOW_W-1:0]};
                  next_pmReq  = 1'b1;
                  next_state  = ST_PFET1;
               end else begin
                  next_dmAddr = cpuReq.addr;
                  next_dmReq  = 1'b1;
                  next_state  = ST_DREAD;
               end
            end
         end
         ST_DREAD: next_state = ST_DCAP;
         ST_DCAP: begin
            next_rsp      = '{data: dmRdData, fromProgram: 1'b0, extra: heldExtra};
            next_rspValid = 1'b1;
            next_state    = ST_IDLE;
         end
         // Second fetch of the same word costs the extra cycle
         ST_PFET1: begin
            next_pmReq = 1'b1;
            next_state = ST_PFET2;
         end
         ST_PFET2: next_state = ST_PCAP;
         ST_PCAP: begin
            next_rsp      = '{data: pmRdData[DATA_W-1:0], fromProgram: 1'b1,
                              extra: heldExtra};
            next_rspValid = 1'b1;
            next_state    = ST_IDLE;
         end
         default: next_state = ST_IDLE;
      endcase
      next_cpuReady = (next_state == ST_IDLE);
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         state     <= ST_IDLE;
         rsp       <= '0;
         rspValid  <= 1'b0;
         cpuReady  <= 1'b1;
         pmReq     <= 1'b0;
         pmAddr    <= '0;
         dmReq     <= 1'b0;
         dmAddr    <= '0;
         heldExtra <= EXTRA_NONE;
      end else begin
         state     <= next_state;
         rsp       <= next_rsp;
         rspValid  <= next_rspValid;
         cpuReady  <= next_cpuReady;
         pmReq     <= next_pmReq;
         pmAddr    <= next_pmAddr;
         dmReq     <= next_dmReq;
         dmAddr    <= next_dmAddr;
         heldExtra <= next_heldExtra;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (rst);

   sequence s_winAccept;
      accept && windowed;
   endsequence

   sequence s_twoFetches;
      pmReq ##1 pmReq ##1 !pmReq;
   endsequence

   sequence s_winBusy;
      !cpuReady [*3] ##1 cpuReady;
   endsequence

   sequence s_ordBusy;
      !cpuReady [*2] ##1 cpuReady;
   endsequence

   chk_page_write: assert property (wrPending && wrOfs == PAGE_OFS
         |=> page == $past(hwdata[PAGE_W-1:0]))
      else $error("page register did not take written value");

   chk_window_decode: assert property (accept && winEnable && cpuReq.addr[ADDR_MSB]
         && !tableActive |=> state == ST_PFET1)
      else $error("windowed access not routed to program memory");

   chk_ordinary_path: assert property (accept && !(winEnable && cpuReq.addr[ADDR_MSB])
         |=> dmReq && !pmReq ##2 rspValid && !rsp.fromProgram && rsp.extra == EXTRA_NONE)
      else $error("ordinary access misrouted or charged");

   chk_prog_addr: assert property (s_winAccept
         |=> pmAddr == {$past(page), $past(cpuReq.addr[LOW_W-1:0])})
      else $error("program address not page over low bits");

   chk_extra_fetch: assert property (s_winAccept |=> s_twoFetches ##1 rspValid)
      else $error("windowed read not one cycle longer");

   chk_low_word: assert property (rspValid && rsp.fromProgram
         |-> rsp.data == $past(pmRdData[DATA_W-1:0]))
      else $error("windowed data not low word");

   chk_table_block: assert property (accept && tableActive |=> !pmReq && dmReq)
      else $error("window used during table operation");

   chk_cost_outside: assert property ((s_winAccept and (!cpuReq.inRepeat))
         |-> ##4 rsp.extra == ($past(cpuReq.kind, 4) == KIND_OTHER ? EXTRA_TWO : EXTRA_ONE))
      else $error("window cost outside repeat wrong");

   chk_cost_repeat: assert property ((s_winAccept and (cpuReq.inRepeat
         && (cpuReq.firstIter || cpuReq.lastIter || cpuReq.intExit || cpuReq.reEntry)))
         |-> ##4 rspValid && rsp.extra == EXTRA_TWO)
      else $error("repeat boundary cost wrong");

   chk_cost_steady: assert property ((s_winAccept and (cpuReq.inRepeat && !cpuReq.firstIter
         && !cpuReq.lastIter && !cpuReq.intExit && !cpuReq.reEntry))
         |-> ##4 rspValid && rsp.extra == EXTRA_NONE)
      else $error("steady repeat iteration charged");

   chk_ctrl_write: assert property (wrPending && wrOfs == CTRL_OFS
         |=> winEnable == $past(hwdata[WIN_EN_BIT]))
      else $error("window enable did not take written value");

   chk_page_read: assert property (addrPhase && !hwrite && haddr[11:0] == PAGE_OFS
         |=> hrdata[PAGE_W-1:0] == $past(page))
      else $error("page register read back wrong");

   chk_count_step: assert property (s_winAccept
         |=> winCount == $past(winCount) + 16'h0001)
      else $error("windowed access not counted");

   chk_ord_data: assert property (rspValid && !rsp.fromProgram
         |-> rsp.data == $past(dmRdData))
      else $error("ordinary data not returned");

   chk_rsp_pulse: assert property (rspValid |=> !rspValid)
      else $error("response held longer than one cycle");

   chk_win_busy: assert property (s_winAccept |=> s_winBusy)
      else $error("windowed access busy time wrong");

   chk_ord_busy: assert property (accept && !windowed |=> s_ordBusy)
      else $error("ordinary access busy time wrong");

   chk_pm_stable: assert property (pmReq && $past(pmReq) |-> pmAddr == $past(pmAddr))
      else $error("second fetch moved the program address");

endmodule // pswd_window

/* dv/pswd_mem_model.sv */
// Behavioural program and data memory facing the window's fetch ports.
// Assumes a one-cycle answer after each request cycle, as the window expects.
`timescale 1ns/10ps
module pswd_mem_model
   import pswd_pkg::*;
(
   input  wire logic                 core_clk,
   input  wire logic                 pmReq,
   input  wire logic [PM_ADDR_W-1:0] pmAddr,
   output logic      [PM_WORD_W-1:0] pmRdData,
   input  wire logic                 dmReq,
   input  wire logic [DATA_W-1:0]    dmAddr,
   output logic      [DATA_W-1:0]    dmRdData
);
   logic                 pmValid;
   logic [PM_ADDR_W-1:0] pmAddrQ;
   logic                 dmValid;
   logic [DATA_W-1:0]    dmAddrQ;
   logic [PM_WORD_W-1:0] pmWord;
   logic [DATA_W-1:0]    dmWord;

   initial begin
      pmValid = 1'b0;
      dmValid = 1'b0;
      pmAddrQ = '0;
      dmAddrQ = '0;
   end

   always @(posedge core_clk) begin
      pmValid <= pmReq;
      dmValid <= dmReq;
      if (pmReq) pmAddrQ <= pmAddr;
      if (dmReq) dmAddrQ <= dmAddr;
   end

   // Constant data kept with an all-ones upper byte so stray execution is harmless
   assign pmWord   = {8'hFF, pmAddrQ[15:0] ^ 16'h5A5A};
   assign dmWord   = dmAddrQ ^ 16'h3C3C;
   // Outside the hold window the lines show garbage, not the last value
   assign pmRdData = pmValid ? pmWord : ~pmWord;
   assign dmRdData = dmValid ? dmWord : ~dmWord;
endmodule // pswd_mem_model

/* dv/testbench.sv */
// Self-checking bench for the program-space data window.
// Assumes the memory model answers the fetch ports; drives AHB-Lite and CPU side.
`timescale 1ns/10ps
module testbench
   import pswd_pkg::*;
;
   logic core_clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, cpuValid = 1'b0, tableActive = 1'b0;
   logic [31:0] haddr = '0, hwdata = '0;
   logic [1:0]  htrans = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic hreadyout, hresp, cpuReady, rspValid, pmReq, dmReq;
   logic [31:0] hrdata;
   pswd_req_type cpuReq = '0;
   pswd_rsp_type rsp;
   logic [PM_ADDR_W-1:0] pmAddr;
   logic [PM_WORD_W-1:0] pmRdData;
   logic [DATA_W-1:0] dmAddr, dmRdData;
   logic [7:0] curPage = 8'h00;
   int fails = 0, checks_done = 0, cycles = 0, winCount = 0;

   pswd_window DUT (.core_clk(core_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(hresp), .hrdata(hrdata), .cpuValid(cpuValid), .cpuReq(cpuReq), .tableActive(tableActive),
      .cpuReady(cpuReady), .rspValid(rspValid), .rsp(rsp), .pmReq(pmReq), .pmAddr(pmAddr),
      .pmRdData(pmRdData), .dmReq(dmReq), .dmAddr(dmAddr), .dmRdData(dmRdData));
   pswd_mem_model mem (.core_clk(core_clk), .pmReq(pmReq), .pmAddr(pmAddr), .pmRdData(pmRdData),
      .dmReq(dmReq), .dmAddr(dmAddr), .dmRdData(dmRdData));

   always #10 core_clk = ~core_clk;

   // ----------------------------------------------------------------
   // Checking and closing
   // ----------------------------------------------------------------
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   always @(posedge core_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fails++;
         stop_test();
      end
   end

   // ----------------------------------------------------------------
   // Bus and CPU drivers, entered just after a rising edge
   // ----------------------------------------------------------------
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
      hsel   <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr  <= {20'h0_0000, a};
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge core_clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      check("hresp", {31'h0, hresp}, 32'h0000_0000);
   endtask

   task automatic cpu_access(input pswd_req_type r, input logic tbl, input logic expWin, input logic [1:0] expExtra);
      int n, pmCnt;
      logic [PM_ADDR_W-1:0] seenPm, expPm;
      logic [DATA_W-1:0] seenDm;
      logic [15:0] expData;
      expPm   = {curPage, r.addr[14:0]};
      expData = expWin ? (expPm[15:0] ^ 16'h5A5A) : (r.addr ^ 16'h3C3C);
      cpuValid    <= 1'b1;
      cpuReq      <= r;
      tableActive <= tbl;
      do @(posedge core_clk); while (cpuReady !== 1'b1);
      cpuValid <= 1'b0;
      n = 0;
      pmCnt = 0;
      seenPm = ~expPm;
      seenDm = ~r.addr;
      do begin
         @(posedge core_clk);
         n++;
         if (pmReq === 1'b1) begin
            seenPm = pmAddr;
            pmCnt++;
         end
         if (dmReq === 1'b1) seenDm = dmAddr;
      end while (rspValid !== 1'b1 && n < 20);
      if (expWin) winCount++;
      check("latency", n, expWin ? 4 : 3);
      check("pm_fetches", pmCnt, expWin ? 2 : 0);
      if (expWin) check("pm_addr", {9'h000, seenPm}, {9'h000, expPm});
      if (!expWin) check("dm_addr", {16'h0000, seenDm}, {16'h0000, r.addr});
      check("data", {16'h0000, rsp.data}, {16'h0000, expData});
      check("from_program", {31'h0, rsp.fromProgram}, {31'h0, expWin});
      check("extra", {30'h0, rsp.extra}, {30'h0, expExtra});
   endtask

   task automatic set_window(input logic [7:0] pg, input logic en);
      logic [31:0] rd;
      ahb(1'b1, PAGE_OFS, {24'h00_0000, pg}, rd);
      ahb(1'b1, CTRL_OFS, {29'h0, en, 2'h0}, rd);
      curPage = pg;
   endtask

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic test_regs();
      logic [31:0] rd;
      ahb(1'b0, PAGE_OFS, 32'h0000_0000, rd); check("page_reset", rd, 32'h0000_0000);
      ahb(1'b0, CTRL_OFS, 32'h0000_0000, rd); check("ctrl_reset", rd, 32'h0000_0000);
      ahb(1'b1, PAGE_OFS, 32'h0000_01A5, rd);
      ahb(1'b0, PAGE_OFS, 32'h0000_0000, rd); check("page_rw", rd, 32'h0000_00A5);
      ahb(1'b1, 12'h00C, 32'hFFFF_FFFF, rd);
      ahb(1'b0, 12'h00C, 32'h0000_0000, rd); check("unmapped", rd, 32'h0000_0000);
   endtask

   task automatic test_kinds();
      pswd_req_type r;
      set_window(8'hA5, 1'b1);
      for (int k = 0; k < 3; k++) begin
         r = '0;
         r.addr = 16'hFEDC;
         r.kind = pswd_kind_type'(k);
         cpu_access(r, 1'b0, 1'b1, (k == 2) ? EXTRA_TWO : EXTRA_ONE);
      end
   endtask

   task automatic test_repeat();
      pswd_req_type r;
      for (int i = 0; i < 5; i++) begin
         r = '0;
         r.addr = 16'h8000 + 16'(i);
         r.kind = KIND_OTHER;
         r.inRepeat = 1'b1;
         {r.firstIter, r.lastIter, r.intExit, r.reEntry} = (i < 4) ? (4'h8 >> i) : 4'h0;
         cpu_access(r, 1'b0, 1'b1, (i < 4) ? EXTRA_TWO : EXTRA_NONE);
      end
   endtask

   task automatic test_ordinary();
      pswd_req_type r;
      r = '0;
      r.addr = 16'h7FFF;
      cpu_access(r, 1'b0, 1'b0, EXTRA_NONE);
      r.addr = 16'h8000;
      cpu_access(r, 1'b1, 1'b0, EXTRA_NONE);
      set_window(8'hA5, 1'b0);
      r.addr = 16'hFFFF;
      cpu_access(r, 1'b0, 1'b0, EXTRA_NONE);
   endtask

   task automatic test_pages();
      pswd_req_type r;
      r = '0;
      r.kind = KIND_WORD;
      set_window(8'h00, 1'b1);
      r.addr = 16'h8000;
      cpu_access(r, 1'b0, 1'b1, EXTRA_ONE);
      set_window(8'hFF, 1'b1);
      r.addr = 16'hFFFF;
      cpu_access(r, 1'b0, 1'b1, EXTRA_ONE);
   endtask

   task automatic test_status();
      logic [31:0] rd;
      ahb(1'b0, STAT_OFS, 32'h0000_0000, rd);
      check("status", rd, {winCount[15:0], 16'h0000});
   endtask

   initial begin
      repeat (12) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      test_regs();
      test_kinds();
      test_repeat();
      test_ordinary();
      test_pages();
      test_status();
      stop_test();
   end
endmodule // testbench
